// ### common/hst_pkg.sv
/*
 * Shared constants and carriers for the converter host controller.
 * Assumes a single 40 MHz clock; every wait is derived from a time constant.
 */
package hst_pkg;

	// ********************************************************
	// Clock and timing helpers
	// ********************************************************

	localparam int unsigned TW = 20;
	localparam int unsigned SYNC_STAGES = 2;
	localparam longint unsigned CLK_PS = 64'd25000;

	// Least times round up to whole cycles, never below one.
	function automatic logic [TW-1:0] cyc_min(input longint unsigned ps);
		longint unsigned c;
		c = (ps + CLK_PS - 64'd1) / CLK_PS;
		return (c == 64'd0) ? TW'(1) : c[TW-1:0];
	endfunction

	// Longest times round down, never below one.
	function automatic logic [TW-1:0] cyc_max(input longint unsigned ps);
		longint unsigned c;
		c = ps / CLK_PS;
		return (c == 64'd0) ? TW'(1) : c[TW-1:0];
	endfunction

	// ********************************************************
	// Printed times
	// ********************************************************

	localparam longint unsigned T_PERIOD_US = 64'd1;
	localparam longint unsigned T_CONV_PULSE_NS = 64'd50;
	localparam longint unsigned T_BUSY_MAX_NS = 64'd32;
	localparam longint unsigned T_CS_SETUP_NS = 64'd20;
	localparam longint unsigned T_CH_SETUP_NS = 64'd50;
	localparam longint unsigned T_CONV_MAX_NS = 64'd520;
	localparam longint unsigned T_ACQ_NS = 64'd480;
	localparam longint unsigned T_QUIET_NS = 64'd50;
	localparam longint unsigned T_PART_RST_NS = 64'd40;
	localparam real T_FULL_RST_US = 1.2;
	localparam longint unsigned T_PART_WAIT_NS = 64'd50;
	localparam longint unsigned T_FULL_CONV_MS = 64'd15;
	localparam longint unsigned T_FULL_WR_US = 64'd240;
	localparam real T_FULL_SETUP_MS = 0.05;
	localparam real T_FULL_HOLD_MS = 0.24;
	localparam longint unsigned T_PART_HOLD_NS = 64'd10;
	localparam longint unsigned T_STROBE_SETUP_NS = 64'd10;
	localparam longint unsigned T_STROBE_LOW_NS = 64'd30;
	localparam longint unsigned T_SETTLE_NS = 64'd20;

	// ********************************************************
	// Cycle counts
	// ********************************************************

	localparam logic [TW-1:0] CYC_PERIOD = cyc_min(T_PERIOD_US * 64'd1000000);
	localparam logic [TW-1:0] CYC_CONV_PULSE = cyc_min(T_CONV_PULSE_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_BUSY_TO = cyc_max(T_BUSY_MAX_NS * 64'd1000) + TW'(SYNC_STAGES + 1);
	localparam logic [TW-1:0] CYC_CS_SETUP = cyc_min(T_CS_SETUP_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_CH_SETUP = cyc_min(T_CH_SETUP_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_CONV_TO = cyc_max(T_CONV_MAX_NS * 64'd1000) + TW'(SYNC_STAGES + 1);
	localparam logic [TW-1:0] CYC_ACQ = cyc_min(T_ACQ_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_QUIET = cyc_min(T_QUIET_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_PART_RST = cyc_min(T_PART_RST_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_FULL_PULSE = cyc_min(longint'(T_FULL_RST_US * 1.0e6));
	localparam logic [TW-1:0] CYC_FULL_SETUP = cyc_min(longint'(T_FULL_SETUP_MS * 1.0e9));
	localparam logic [TW-1:0] CYC_FULL_RST =
		(CYC_FULL_SETUP > CYC_FULL_PULSE) ? CYC_FULL_SETUP : CYC_FULL_PULSE;
	localparam logic [TW-1:0] CYC_PART_WAIT = cyc_min(T_PART_WAIT_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_FULL_CONV = cyc_min(T_FULL_CONV_MS * 64'd1000000000);
	localparam logic [TW-1:0] CYC_FULL_WR = cyc_min(T_FULL_WR_US * 64'd1000000);
	localparam logic [TW-1:0] CYC_FULL_HOLD = cyc_min(longint'(T_FULL_HOLD_MS * 1.0e9));
	localparam logic [TW-1:0] CYC_PART_HOLD = cyc_min(T_PART_HOLD_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_STB_SETUP = cyc_min(T_STROBE_SETUP_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_STB_LOW = cyc_min(T_STROBE_LOW_NS * 64'd1000);
	localparam logic [TW-1:0] CYC_RD_LOW = CYC_STB_LOW + TW'(SYNC_STAGES + 1);
	localparam logic [TW-1:0] CYC_SETTLE = cyc_min(T_SETTLE_NS * 64'd1000);

	// ********************************************************
	// Carriers
	// ********************************************************

	localparam int unsigned DW = 16;
	localparam int unsigned FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		CMD_WRITE = 2'h0,
		CMD_PART_RST = 2'h1,
		CMD_FULL_RST = 2'h2
	} hst_cmd_e;

	typedef struct packed {
		hst_cmd_e kind;
		logic [DW-1:0] data;
	} hst_cmd_s;

	typedef struct packed {
		logic [DW-1:0] chan_a;
		logic [DW-1:0] chan_b;
	} hst_result_s;

	typedef struct packed {
		logic conversion_start;
		logic reset_n;
		logic cs_n;
		logic rd_n;
		logic wr_n;
	} hst_pins_s;

	localparam hst_pins_s PINS_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ### core/hst_ctrl.sv
/*
 * Host controller for a dual simultaneous-sampling converter: parallel port
 * reads, configuration writes, reset pulses and a result FIFO.
 * Assumes the converter pins are asynchronous to i_ref_clk and that the
 * testbench resolves the shared data bus from o_parallel_data_bus_oe.
 */
// Operation
// - Space conversion-start rising edges at least 1 us apart.
// - Hold conversion-start low and high at least 50 ns each.
// - After busy falls wait 20 ns before chip select for reads.
// - Allow 480 ns acquisition between conversions.
// - Wait 50 ns from chip select release to next conversion start.
// - Partial reset is a low pulse from 40 ns to 500 ns.
// - Full reset is a low pulse of at least 1.2 us.
// - After partial reset wait 50 ns before conversion or write.
// - After full reset wait 15 ms before conversion start.
// - After full reset wait 240 us before a write.
// - Configuration inputs stable before reset release: 10 ns or 0.05 ms.
// - Configuration inputs stable after reset release: 10 ns or 0.24 ms.
// - Chip select 10 ns before read strobe; read strobe released first.
// - Wait 20 ns from write strobe rising to conversion start.
`timescale 1ns/1ps

// ********************************************************
// Result FIFO
// ********************************************************

module hst_fifo #(
	parameter int unsigned W = 32,
	parameter int unsigned D = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire logic push;
	wire logic pop;

	// Full and empty come from the count, so both stay exact on wrap.
	assign o_in_ready = (count_q != (AW+1)'(D));
	assign o_out_valid = (count_q != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rd_ptr_q];

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
			begin
				mem_q[wr_ptr_q] <= i_in_data;
				wr_ptr_q <= (wr_ptr_q == AW'(D - 1)) ? '0 : wr_ptr_q + AW'(1);
			end
			if (pop)
				rd_ptr_q <= (rd_ptr_q == AW'(D - 1)) ? '0 : rd_ptr_q + AW'(1);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ********************************************************
// Controller
// ********************************************************

module hst_ctrl #(
	parameter logic [hst_pkg::TW-1:0] FULL_CONV_CYC = hst_pkg::CYC_FULL_CONV,
	parameter logic [hst_pkg::TW-1:0] FULL_WR_CYC = hst_pkg::CYC_FULL_WR,
	parameter logic [hst_pkg::TW-1:0] FULL_HOLD_CYC = hst_pkg::CYC_FULL_HOLD
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire hst_pkg::hst_cmd_s i_cmd,
	input wire logic [3:0] i_channel_select,
	output logic o_res_valid,
	input wire logic i_res_ready,
	output hst_pkg::hst_result_s o_res,
	output logic o_err,
	input wire logic i_err_clr,
	output hst_pkg::hst_pins_s o_pins,
	output logic [3:0] o_channel_select,
	input wire logic i_busy,
	input wire logic [hst_pkg::DW-1:0] i_parallel_data_bus,
	output logic [hst_pkg::DW-1:0] o_parallel_data_bus,
	output logic o_parallel_data_bus_oe
);
	localparam int unsigned TW = hst_pkg::TW;
	localparam int unsigned DW = hst_pkg::DW;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CONV_HI = 4'h1,
		ST_WAIT_BUSY = 4'h3,
		ST_CONV = 4'h2,
		ST_CS_GAP = 4'h6,
		ST_RD_SETUP = 4'h7,
		ST_RD_LOW = 4'h5,
		ST_RD_HIGH = 4'h4,
		ST_RD_HOLD = 4'hC,
		ST_WR_WAIT = 4'hD,
		ST_WR_SETUP = 4'hF,
		ST_WR_LOW = 4'hE,
		ST_WR_HOLD = 4'hA,
		ST_RST_LOW = 4'hB
	} hst_state_e;

	// A blocking counter runs down and is only ever pushed further out.
	function automatic logic [TW-1:0] hold_off(input logic [TW-1:0] q, input logic [TW-1:0] ld);
		logic [TW-1:0] dec;
		dec = (q != '0) ? q - TW'(1) : '0;
		return (ld > dec) ? ld : dec;
	endfunction

	hst_state_e st_q, st_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic [TW-1:0] conv_blk_q, wr_blk_q, per_q, hold_q;
	logic [TW-1:0] conv_ld, wr_ld, per_ld, hold_ld;
	hst_pkg::hst_pins_s pins_d;
	hst_pkg::hst_cmd_s cmd_q, cmd_d;
	hst_pkg::hst_result_s res_q, res_d;
	logic [DW-1:0] db_d;
	logic oe_d, word_q, word_d, push_q, push_d, err_set, ready_d;
	logic [3:0] chan_d;
	logic busy_m_q, busy_s_q;
	logic [DW-1:0] db_m_q, db_s_q;
	wire logic fifo_in_ready;
	wire logic tmr_zero;
	wire logic conv_ok;
	wire logic chan_upd;

	// ********************************************************
	// Pin synchronisers
	// ********************************************************

	// Busy and the data bus are asynchronous; only the second stage is read.
	always_ff @(posedge i_ref_clk)
	begin
		busy_m_q <= i_busy;
		busy_s_q <= busy_m_q;
		db_m_q <= i_parallel_data_bus;
		db_s_q <= db_m_q;
	end

	// ********************************************************
	// Decodes
	// ********************************************************

	// A full FIFO throttles sampling, so a stalled reader never loses results.
	assign tmr_zero = (tmr_q == '0);
	assign conv_ok = i_run && fifo_in_ready && !chan_upd
		&& (conv_blk_q == '0) && (per_q == '0);
	// Configuration inputs freeze through a reset pulse and its hold window.
	assign chan_upd = (st_q == ST_IDLE) && (hold_q == '0) && !(i_cmd_valid && o_cmd_ready)
		&& (i_channel_select != o_channel_select);
	assign chan_d = chan_upd ? i_channel_select : o_channel_select;

	// ********************************************************
	// Sequencer
	// ********************************************************

	// One timer paces every state but idle and write wait; a state lasts its loaded count plus one, a busy wait at most that.
	always_comb
	begin
		st_d = st_q;
		tmr_d = tmr_zero ? '0 : tmr_q - TW'(1);
		pins_d = o_pins;
		db_d = o_parallel_data_bus;
		oe_d = o_parallel_data_bus_oe;
		cmd_d = cmd_q;
		res_d = res_q;
		word_d = word_q;
		push_d = 1'b0;
		err_set = 1'b0;
		conv_ld = chan_upd ? hst_pkg::CYC_CH_SETUP : '0;
		wr_ld = '0;
		per_ld = '0;
		hold_ld = '0;
		unique case (st_q)
			ST_IDLE:
			begin
				if (i_cmd_valid && o_cmd_ready)
				begin
					cmd_d = i_cmd;
					if (i_cmd.kind == hst_pkg::CMD_WRITE)
						st_d = ST_WR_WAIT;
					else
					begin
						pins_d.reset_n = 1'b0;
						tmr_d = ((i_cmd.kind == hst_pkg::CMD_FULL_RST) ?
							hst_pkg::CYC_FULL_RST : hst_pkg::CYC_PART_RST) - TW'(1);
						st_d = ST_RST_LOW;
					end
				end
				else if (conv_ok)
				begin
					pins_d.conversion_start = 1'b1;
					tmr_d = hst_pkg::CYC_CONV_PULSE - TW'(1);
					per_ld = hst_pkg::CYC_PERIOD - TW'(1);
					st_d = ST_CONV_HI;
				end
			end
			ST_CONV_HI:
			begin
				if (tmr_zero)
				begin
					pins_d.conversion_start = 1'b0;
					conv_ld = hst_pkg::CYC_CONV_PULSE;
					tmr_d = hst_pkg::CYC_BUSY_TO;
					st_d = ST_WAIT_BUSY;
				end
			end
			ST_WAIT_BUSY:
			begin
				if (busy_s_q)
				begin
					tmr_d = hst_pkg::CYC_CONV_TO;
					st_d = ST_CONV;
				end
				else if (tmr_zero)
				begin
					err_set = 1'b1;
					st_d = ST_IDLE;
				end
			end
			ST_CONV:
			begin
				if (!busy_s_q)
				begin
					conv_ld = hst_pkg::CYC_ACQ;
					tmr_d = hst_pkg::CYC_CS_SETUP - TW'(1);
					st_d = ST_CS_GAP;
				end
				else if (tmr_zero)
				begin
					err_set = 1'b1;
					st_d = ST_IDLE;
				end
			end
			ST_CS_GAP:
			begin
				if (tmr_zero)
				begin
					pins_d.cs_n = 1'b0;
					word_d = 1'b0;
					tmr_d = hst_pkg::CYC_STB_SETUP - TW'(1);
					st_d = ST_RD_SETUP;
				end
			end
			ST_RD_SETUP, ST_RD_HIGH:
			begin
				if (tmr_zero)
				begin
					pins_d.rd_n = 1'b0;
					word_d = (st_q == ST_RD_HIGH);
					tmr_d = hst_pkg::CYC_RD_LOW - TW'(1);
					st_d = ST_RD_LOW;
				end
			end
			ST_RD_LOW:
			begin
				if (tmr_zero)
				begin
					pins_d.rd_n = 1'b1;
					if (word_q)
					begin
						res_d.chan_b = db_s_q;
						tmr_d = hst_pkg::CYC_STB_SETUP - TW'(1);
						st_d = ST_RD_HOLD;
					end
					else
					begin
						res_d.chan_a = db_s_q;
						tmr_d = hst_pkg::CYC_STB_SETUP - TW'(1);
						st_d = ST_RD_HIGH;
					end
				end
			end
			ST_RD_HOLD:
			begin
				if (tmr_zero)
				begin
					pins_d.cs_n = 1'b1;
					push_d = 1'b1;
					conv_ld = hst_pkg::CYC_QUIET;
					st_d = ST_IDLE;
				end
			end
			ST_WR_WAIT:
			begin
				if (wr_blk_q == '0)
				begin
					pins_d.cs_n = 1'b0;
					oe_d = 1'b1;
					db_d = cmd_q.data;
					tmr_d = hst_pkg::CYC_STB_SETUP - TW'(1);
					st_d = ST_WR_SETUP;
				end
			end
			ST_WR_SETUP:
			begin
				if (tmr_zero)
				begin
					pins_d.wr_n = 1'b0;
					tmr_d = hst_pkg::CYC_STB_LOW - TW'(1);
					st_d = ST_WR_LOW;
				end
			end
			ST_WR_LOW:
			begin
				if (tmr_zero)
				begin
					pins_d.wr_n = 1'b1;
					conv_ld = hst_pkg::CYC_SETTLE;
					tmr_d = hst_pkg::CYC_STB_SETUP - TW'(1);
					st_d = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD:
			begin
				if (tmr_zero)
				begin
					pins_d.cs_n = 1'b1;
					oe_d = 1'b0;
					conv_ld = hst_pkg::CYC_QUIET;
					st_d = ST_IDLE;
				end
			end
			ST_RST_LOW:
			begin
				if (tmr_zero)
				begin
					pins_d.reset_n = 1'b1;
					if (cmd_q.kind == hst_pkg::CMD_FULL_RST)
					begin
						conv_ld = FULL_CONV_CYC;
						wr_ld = FULL_WR_CYC;
						hold_ld = FULL_HOLD_CYC;
					end
					else
					begin
						conv_ld = hst_pkg::CYC_PART_WAIT;
						wr_ld = hst_pkg::CYC_PART_WAIT;
						hold_ld = hst_pkg::CYC_PART_HOLD;
					end
					st_d = ST_IDLE;
				end
			end
			default:
			begin
				st_d = ST_IDLE;
				pins_d = hst_pkg::PINS_RESET;
				oe_d = 1'b0;
			end
		endcase
		ready_d = (st_d == ST_IDLE);
	end

	// ********************************************************
	// State registers
	// ********************************************************

	// The sticky error lets a new timeout win over a clear in the same cycle.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			st_q <= ST_IDLE;
			tmr_q <= '0;
			o_pins <= hst_pkg::PINS_RESET;
			o_parallel_data_bus <= '0;
			o_parallel_data_bus_oe <= 1'b0;
			o_channel_select <= '0;
			o_cmd_ready <= 1'b0;
			o_err <= 1'b0;
			cmd_q <= '0;
			res_q <= '0;
			word_q <= 1'b0;
			push_q <= 1'b0;
			conv_blk_q <= '0;
			wr_blk_q <= '0;
			per_q <= '0;
			hold_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			o_pins <= pins_d;
			o_parallel_data_bus <= db_d;
			o_parallel_data_bus_oe <= oe_d;
			o_channel_select <= chan_d;
			o_cmd_ready <= ready_d;
			o_err <= err_set || (o_err && !i_err_clr);
			cmd_q <= cmd_d;
			res_q <= res_d;
			word_q <= word_d;
			push_q <= push_d;
			conv_blk_q <= hold_off(conv_blk_q, conv_ld);
			wr_blk_q <= hold_off(wr_blk_q, wr_ld);
			per_q <= hold_off(per_q, per_ld);
			hold_q <= hold_off(hold_q, hold_ld);
		end
	end

	// ********************************************************
	// Result buffer
	// ********************************************************

	// Each conversion pushes one word holding both channels of the pair.
	hst_fifo #(
		.W($bits(hst_pkg::hst_result_s)),
		.D(hst_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_in_valid(push_q),
		.o_in_ready(fifo_in_ready),
		.i_in_data(res_q),
		.o_out_valid(o_res_valid),
		.i_out_ready(i_res_ready),
		.o_out_data(o_res)
	);
endmodule

// ### testbench/hst_ctrl_props.sv
/*
 * Timing checker for the converter host controller pins.
 * Assumes it is bound to hst_ctrl and sees only that module's ports.
 */
`timescale 1ns/1ps

module hst_ctrl_props #(
	parameter logic [hst_pkg::TW-1:0] FULL_CONV_CYC = hst_pkg::CYC_FULL_CONV,
	parameter logic [hst_pkg::TW-1:0] FULL_WR_CYC = hst_pkg::CYC_FULL_WR,
	parameter logic [hst_pkg::TW-1:0] FULL_HOLD_CYC = hst_pkg::CYC_FULL_HOLD
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_busy,
	input wire hst_pkg::hst_pins_s o_pins,
	input wire logic [3:0] o_channel_select,
	input wire logic o_parallel_data_bus_oe
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// ********
	// Interval counters
	// ********

	logic conv_p_q, rst_p_q, busy_p_q, full_q;
	logic [7:0] conv_q, acq_q;
	logic [11:0] low_q;
	logic [19:0] rel_q;

	// Counters saturate so a long idle time never wraps into a short one.
	wire conv_rise = o_pins.conversion_start && !conv_p_q;
	wire rst_rise = o_pins.reset_n && !rst_p_q;
	wire [7:0] conv_d = conv_rise ? 8'h01 : conv_q + {7'h00, ~&conv_q};
	wire [7:0] acq_d = (busy_p_q && !i_busy) ? 8'h01 : acq_q + {7'h00, ~&acq_q};
	wire [11:0] low_d = o_pins.reset_n ? 12'h000 : low_q + {11'h000, ~&low_q};
	wire [19:0] rel_d = rst_rise ? 20'h0_0001 : rel_q + {19'h0_0000, ~&rel_q};
	wire full_d = rst_rise ? (low_q >= 12'h030) : full_q;

	// Previous pin levels and the reset low-time count.
	always_ff @(posedge i_ref_clk)
	begin
		conv_p_q <= o_pins.conversion_start;
		rst_p_q <= o_pins.reset_n;
		busy_p_q <= i_busy;
		low_q <= low_d;
	end

	// A controller reset forgets earlier events rather than flag them.
	always_ff @(posedge i_ref_clk)
	begin
		conv_q <= i_rst ? 8'hFF : conv_d;
		acq_q <= i_rst ? 8'hFF : acq_d;
		rel_q <= i_rst ? '1 : rel_d;
		full_q <= i_rst ? 1'b0 : full_d;
	end

	// ********
	// Pin timing
	// ********

	conv_high_a: assert property (
		$rose(o_pins.conversion_start) |=> o_pins.conversion_start) else $error("short start high");
	conv_low_a: assert property (
		$fell(o_pins.conversion_start) |=> !o_pins.conversion_start) else $error("short start low");
	conv_period_a: assert property (
		conv_rise |-> conv_q >= 8'h28) else $error("start edges too close");
	acq_gap_a: assert property (
		conv_rise |-> acq_q >= 8'h14) else $error("acquisition too short");
	cs_setup_a: assert property (
		$fell(o_pins.cs_n) |-> !i_busy && !$past(i_busy) && !$past(i_busy, 2))
		else $error("select while busy");
	rd_setup_a: assert property (
		$fell(o_pins.rd_n) |-> !o_pins.cs_n && !$past(o_pins.cs_n)) else $error("read strobe early");
	rd_hold_a: assert property (
		$rose(o_pins.cs_n) |-> o_pins.rd_n && $past(o_pins.rd_n)) else $error("read strobe late");
	quiet_gap_a: assert property (
		$rose(o_pins.cs_n) |-> !conv_rise ##1 !conv_rise) else $error("no quiet time");
	settle_gap_a: assert property (
		$rose(o_pins.wr_n) |-> !conv_rise) else $error("no settle time");
	rst_width_a: assert property (
		rst_rise |-> low_q >= 12'h002 && (low_q <= 12'h014 || low_q >= 12'h030))
		else $error("bad reset width");
	part_wait_a: assert property (
		rst_rise |-> (!conv_rise && !$fell(o_pins.cs_n)) ##1 (!conv_rise && !$fell(o_pins.cs_n)))
		else $error("early access after reset");
	full_conv_a: assert property (
		conv_rise |-> o_pins.reset_n && (!full_q || rel_q >= FULL_CONV_CYC))
		else $error("early start after full reset");
	full_wr_a: assert property (
		$fell(o_pins.cs_n) && o_parallel_data_bus_oe |-> !full_q || rel_q >= FULL_WR_CYC)
		else $error("early write after full reset");
	cfg_hold_a: assert property (
		$changed(o_channel_select) |-> o_pins.reset_n && !rst_rise
		&& rel_q >= (full_q ? FULL_HOLD_CYC : 20'h0_0001)) else $error("channel moved near reset");
endmodule

bind hst_ctrl hst_ctrl_props #(
	.FULL_CONV_CYC(FULL_CONV_CYC),
	.FULL_WR_CYC(FULL_WR_CYC),
	.FULL_HOLD_CYC(FULL_HOLD_CYC)
) u_hst_ctrl_props (
	.i_ref_clk(i_ref_clk),
	.i_rst(i_rst),
	.i_busy(i_busy),
	.o_pins(o_pins),
	.o_channel_select(o_channel_select),
	.o_parallel_data_bus_oe(o_parallel_data_bus_oe)
);

// ### testbench/hst_dev_model.sv
/*
 * Behavioural converter on the parallel port: busy, two result reads,
 * configuration writes and reset width decoding.
 * Assumes the bench resolves the shared bus and feeds it to i_bus.
 */
`timescale 1ns/1ps

module hst_dev_model (
	input wire logic i_no_busy,
	input wire hst_pkg::hst_pins_s i_pins,
	input wire logic [15:0] i_bus,
	output logic o_busy,
	output logic [15:0] o_bus,
	output logic [15:0] o_last_wr,
	output logic [1:0] o_rst_kind,
	output logic [11:0] o_conv_cnt
);
	realtime fall_t = -1.0;
	realtime width;
	logic sel = 1'b0;
	logic [11:0] idx = 12'h000;

	initial
	begin
		o_busy = 1'b0;
		o_bus = 16'h0000;
		o_last_wr = 16'h0000;
		o_rst_kind = 2'h0;
		o_conv_cnt = 12'h000;
	end

	// Busy pulse per start edge; i_no_busy plays a dead converter.
	always @(posedge i_pins.conversion_start)
		if (!i_no_busy)
		begin
			idx = o_conv_cnt;
			o_conv_cnt = o_conv_cnt + 12'h001;
			#20 o_busy = 1'b1;
			#475 o_busy = 1'b0;
		end

	// Data is garbage until the access time passes, and after the strobe.
	always @(negedge i_pins.cs_n) sel = 1'b0;
	always @(negedge i_pins.rd_n)
	begin
		o_bus = ~o_bus;
		#30 o_bus = sel ? {4'h5, idx} : {4'hA, idx};
	end
	always @(posedge i_pins.rd_n)
	begin
		sel = ~sel;
		#5 o_bus = ~o_bus;
	end

	// Configuration word is taken on the write strobe rising edge.
	always @(posedge i_pins.wr_n) if (!i_pins.cs_n) o_last_wr = i_bus;

	// Reset kind from pulse width: 1 partial, 2 full, 3 neither.
	always @(negedge i_pins.reset_n) fall_t = $realtime;
	always @(posedge i_pins.reset_n)
		if (fall_t >= 0.0)
		begin
			width = $realtime - fall_t;
			o_rst_kind = (width >= 1200.0) ? 2'h2 :
				(width >= 40.0 && width <= 500.0) ? 2'h1 : 2'h3;
		end
endmodule

// ### testbench/testbench.sv
/*
 * Self-checking bench for hst_ctrl with the converter model on its pins.
 * Assumes shortened full-reset hold-offs through the design parameters.
 */
`timescale 1ns/1ps

module testbench;
	logic i_ref_clk, i_rst, i_run, i_cmd_valid, i_res_ready, i_err_clr, no_busy;
	logic o_cmd_ready, o_res_valid, o_err, o_parallel_data_bus_oe, dev_busy;
	hst_pkg::hst_cmd_s i_cmd;
	hst_pkg::hst_result_s o_res;
	hst_pkg::hst_pins_s o_pins;
	logic [3:0] i_channel_select, o_channel_select;
	logic [15:0] o_parallel_data_bus, dev_bus, last_wr;
	logic [1:0] rst_kind;
	logic [11:0] conv_cnt;
	logic [11:0] exp_n = 12'h000;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	wire [15:0] bus_w = o_parallel_data_bus_oe ? o_parallel_data_bus : dev_bus;

	// Command rows with the write word and reset kind the converter should then hold.
	hst_pkg::hst_cmd_e row_k [5] = '{hst_pkg::CMD_WRITE, hst_pkg::CMD_PART_RST,
		hst_pkg::CMD_WRITE, hst_pkg::CMD_FULL_RST, hst_pkg::CMD_WRITE};
	logic [15:0] row_d [5] = '{16'h1234, 16'h0000, 16'hABCD, 16'h0000, 16'h00FF};
	logic [15:0] row_w [5] = '{16'h1234, 16'h1234, 16'hABCD, 16'hABCD, 16'h00FF};
	logic [1:0] row_r [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

	hst_ctrl #(.FULL_CONV_CYC(20'h0_00C8), .FULL_WR_CYC(20'h0_0032), .FULL_HOLD_CYC(20'h0_0032))
	u_hst_ctrl (.i_ref_clk, .i_rst, .i_run, .i_cmd_valid, .o_cmd_ready, .i_cmd,
		.i_channel_select, .o_res_valid, .i_res_ready, .o_res, .o_err, .i_err_clr, .o_pins,
		.o_channel_select, .i_busy(dev_busy), .i_parallel_data_bus(bus_w),
		.o_parallel_data_bus, .o_parallel_data_bus_oe);

	hst_dev_model u_hst_dev_model (.i_no_busy(no_busy), .i_pins(o_pins), .i_bus(bus_w),
		.o_busy(dev_busy), .o_bus(dev_bus), .o_last_wr(last_wr), .o_rst_kind(rst_kind),
		.o_conv_cnt(conv_cnt));

	initial
	begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	// ********
	// Checking helpers
	// ********

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Offers row i and waits until the sequencer is idle again.
	task automatic send(input int i);
		i_channel_select <= 4'h5 ^ i[3:0];
		i_cmd_valid <= 1'b1;
		i_cmd <= '{row_k[i], row_d[i]};
		do @(posedge i_ref_clk); while (o_cmd_ready !== 1'b1);
		i_cmd_valid <= 1'b0;
		@(posedge i_ref_clk);
		do @(posedge i_ref_clk); while (o_cmd_ready !== 1'b1);
	endtask

	// Every popped word must be the next pair in conversion order.
	always @(posedge i_ref_clk)
		if (o_res_valid === 1'b1 && i_res_ready === 1'b1)
		begin
			check("result", {4'hA, exp_n, 4'h5, exp_n}, o_res);
			exp_n <= exp_n + 12'h001;
		end

	// A hang ends the run as a failure.
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			failures++;
			print_verdict();
		end
	end

	// ********
	// Main sequence
	// ********

	initial
	begin
		i_rst = 1'b1;
		i_run = 1'b0;
		i_cmd_valid = 1'b0;
		i_cmd = '0;
		i_res_ready = 1'b0;
		i_err_clr = 1'b0;
		no_busy = 1'b0;
		i_channel_select = 4'h5;
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		check("pins", hst_pkg::PINS_RESET, o_pins);
		check("idle", 32'h0000_0000, {o_err, o_res_valid, o_parallel_data_bus_oe});
		for (int i = 0; i < 5; i++)
		begin
			send(i);
			check("last_wr", row_w[i], last_wr);
			check("rst_kind", row_r[i], rst_kind);
		end
		repeat (10) @(posedge i_ref_clk);
		check("chan_sel", 32'h0000_0001, o_channel_select);
		// Far side stalls: the buffer fills and no further conversion starts.
		i_run <= 1'b1;
		repeat (1200) @(posedge i_ref_clk);
		check("fill", 32'h0000_0010, conv_cnt);
		i_res_ready <= 1'b1;
		repeat (300) @(posedge i_ref_clk);
		i_run <= 1'b0;
		repeat (100) @(posedge i_ref_clk);
		check("drain", conv_cnt, exp_n);
		check("empty", 32'h0000_0000, o_res_valid);
		// Dead converter: busy never comes.
		i_res_ready <= 1'b0;
		no_busy <= 1'b1;
		i_run <= 1'b1;
		for (int n = 0; n < 100 && o_err !== 1'b1; n++) @(posedge i_ref_clk);
		i_run <= 1'b0;
		check("err_set", 32'h0000_0001, o_err);
		repeat (60) @(posedge i_ref_clk);
		i_err_clr <= 1'b1;
		@(posedge i_ref_clk);
		i_err_clr <= 1'b0;
		@(posedge i_ref_clk);
		check("err_clr", 32'h0000_0000, o_err);
		// Reset again with run off and the sequencer idle.
		i_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		check("pins_rst", hst_pkg::PINS_RESET, o_pins);
		check("rdy_rst", 32'h0000_0000, o_cmd_ready);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		@(posedge i_ref_clk);
		check("rdy_rel", 32'h0000_0001, o_cmd_ready);
		print_verdict();
	end
endmodule
